// >>> design/fts_sram_ctl.sv
/*
 * pin-control logic of a flow-through burst memory: select decode, clock gate,
 * burst sequencing, write data capture, read return, output masking and sleep.
 * assumes the storage array sits outside, reads combinationally from o_mem_raddr
 * and writes the lanes flagged in o_mem_lane_we on an edge where o_mem_we is high.
 */
`timescale 1ns/1ps
module fts_sram_ctl (
  // clock and reset
  input  wire logic                        i_clk_sys,
  input  wire logic                        i_rst_n,
  // synchronous control pins
  input  wire logic                        i_clock_gate_l,
  input  wire logic                        i_select_first_l,
  input  wire logic                        i_select_second_h,
  input  wire logic                        i_select_third_l,
  input  wire logic                        i_advance_or_load,
  input  wire logic                        i_write_req_l,
  input  wire logic [fts_pkg::LANES-1:0]   i_byte_lane_write_l,
  // address pins
  input  wire logic [fts_pkg::HI_W-1:0]    i_addr_hi,
  input  wire logic                        i_burst_start_bit0,
  input  wire logic                        i_burst_start_bit1,
  // asynchronous and strap pins
  input  wire logic                        i_output_drive_l,
  input  wire logic                        i_sleep_request,
  input  wire logic                        i_burst_order_strap,
  // data and parity pins
  input  wire logic [fts_pkg::DATA_W-1:0]  i_dq,
  output logic      [fts_pkg::DATA_W-1:0]  o_dq,
  output logic                             o_dq_oe_n,
  input  wire logic [fts_pkg::LANES-1:0]   i_parity_lines,
  output logic      [fts_pkg::LANES-1:0]   o_parity_lines,
  output logic                             o_parity_oe_n,
  // storage array port
  output logic      [fts_pkg::ADDR_W-1:0]  o_mem_raddr,
  input  wire logic [fts_pkg::WORD_W-1:0]  i_mem_rdata,
  output logic                             o_mem_we,
  output logic      [fts_pkg::ADDR_W-1:0]  o_mem_waddr,
  output logic      [fts_pkg::WORD_W-1:0]  o_mem_wdata,
  output logic      [fts_pkg::LANES-1:0]   o_mem_lane_we,
  // status
  output logic                             o_sleep_active
);
  import fts_pkg::*;

  // ****************************************************************
  // declarations
  // ****************************************************************
  fts_burst_if burst ();

  logic                en;
  logic                selected;
  fts_op_t             cur_op;
  fts_op_t             next_op;
  logic                first_desel;
  logic                next_first_desel;
  logic [HI_W-1:0]     addr_hi;
  logic [HI_W-1:0]     next_addr_hi;
  logic [LANES-1:0]    lanes_l;
  logic [LANES-1:0]    next_lanes_l;
  logic                mem_we_q;
  logic                next_mem_we;
  logic [ADDR_W-1:0]   waddr;
  logic [ADDR_W-1:0]   next_waddr;
  logic [WORD_W-1:0]   wdata;
  logic [WORD_W-1:0]   next_wdata;
  logic [LANES-1:0]    wlanes;
  logic [LANES-1:0]    next_wlanes;
  logic                sleep_s1;
  logic                sleep_s2;
  logic                sleep_s3;
  logic                asleep;
  logic                next_asleep;
  logic                linear;
  logic                drive_ok;
  logic [WORD_W-1:0]   pin_word;

  // ****************************************************************
  // qualification and select decode
  // ****************************************************************
  // every state update below except the strap capture is gated by en, so a high gate is a pure stall
  assign en       = !i_clock_gate_l;
  assign selected = !i_select_first_l && i_select_second_h && !i_select_third_l;

  // ****************************************************************
  // burst order strap
  // ****************************************************************
  // the strap is static, so it is caught while reset is held and then kept
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      linear <= (i_burst_order_strap == STRAP_LINEAR);
    end
  end

  // ****************************************************************
  // sleep synchroniser
  // ****************************************************************
  // three stages, the level moves only once stages two and three agree
  always_comb begin
    next_asleep = asleep;
    if (sleep_s2 == sleep_s3) begin
      next_asleep = sleep_s3;
    end
  end

  // reset value is deasserted, matching an input left undriven
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      sleep_s1 <= SLEEP_RST;
      sleep_s2 <= SLEEP_RST;
      sleep_s3 <= SLEEP_RST;
      asleep   <= SLEEP_RST;
    end else if (en) begin
      sleep_s1 <= i_sleep_request;
      sleep_s2 <= sleep_s1;
      sleep_s3 <= sleep_s2;
      asleep   <= next_asleep;
    end
  end

  assign o_sleep_active = asleep;

  // ****************************************************************
  // pin word packing
  // ****************************************************************
  // each lane holds its byte with the parity bit on top
  always_comb begin
    pin_word = '0;
    for (int k = 0; k < LANES; k++) begin
      pin_word[k*LANE_W +: LANE_D]      = i_dq[k*LANE_D +: LANE_D];
      pin_word[k*LANE_W + LANE_D]       = i_parity_lines[k];
    end
  end

  // ****************************************************************
  // access sequencer
  // ****************************************************************
  // a write's data follows its address by one qualified edge, so the data
  // edge commits the previous command while a new one is already decoded
  always_comb begin
    next_op          = cur_op;
    next_addr_hi     = addr_hi;
    next_lanes_l     = lanes_l;
    next_mem_we      = 1'b0;
    next_waddr       = waddr;
    next_wdata       = wdata;
    next_wlanes      = wlanes;
    burst.load       = 1'b0;
    burst.step       = 1'b0;
    // data phase of a write: register the pins and hand them to the array
    if (cur_op == OP_WRITE && !asleep) begin
      next_mem_we = 1'b1;
      next_waddr  = o_mem_raddr;
      next_wdata  = pin_word;
      next_wlanes = ~lanes_l;
    end
    if (asleep) begin
      // sleeping blocks new accesses, so the array is left untouched
      next_op = OP_DESEL;
    end else if (!i_advance_or_load) begin
      if (selected) begin
        burst.load   = 1'b1;
        next_addr_hi = i_addr_hi;
        next_lanes_l = i_byte_lane_write_l;
        next_op      = i_write_req_l ? OP_READ : OP_WRITE;
      end else begin
        next_op = OP_DESEL;
      end
    end else if (cur_op != OP_DESEL) begin
      // continue the burst with the same direction and fresh lane selects
      burst.step   = 1'b1;
      next_lanes_l = i_byte_lane_write_l;
    end
    next_first_desel = (cur_op == OP_DESEL) && (next_op != OP_DESEL);
  end

  // gate high holds everything, so the stretched cycle keeps its select
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      cur_op      <= OP_DESEL;
      first_desel <= 1'b0;
      addr_hi     <= '0;
      lanes_l     <= '1;
      mem_we_q    <= 1'b0;
      waddr       <= '0;
      wdata       <= '0;
      wlanes      <= '0;
    end else if (en) begin
      cur_op      <= next_op;
      first_desel <= next_first_desel;
      addr_hi     <= next_addr_hi;
      lanes_l     <= next_lanes_l;
      mem_we_q    <= next_mem_we;
      waddr       <= next_waddr;
      wdata       <= next_wdata;
      wlanes      <= next_wlanes;
    end
  end

  // ****************************************************************
  // burst counter
  // ****************************************************************
  assign burst.linear = linear;
  assign burst.seed   = {i_burst_start_bit1, i_burst_start_bit0};

  fts_burst_ctr u_burst (
    .i_clk_sys (i_clk_sys),
    .i_rst_n   (i_rst_n),
    .i_en      (en),
    .bus       (burst.ctr)
  );

  // ****************************************************************
  // array port
  // ****************************************************************
  // the write strobe is qualified so a stalled edge never writes twice
  assign o_mem_raddr   = {addr_hi, burst.addr_low};
  assign o_mem_we      = mem_we_q && en;
  assign o_mem_waddr   = waddr;
  assign o_mem_wdata   = wdata;
  assign o_mem_lane_we = wlanes;

  // ****************************************************************
  // output return and drive control
  // ****************************************************************
  // flow-through: the array word for the latched address goes straight out
  always_comb begin
    o_dq           = '0;
    o_parity_lines = '0;
    for (int k = 0; k < LANES; k++) begin
      o_dq[k*LANE_D +: LANE_D] = i_mem_rdata[k*LANE_W +: LANE_D];
      o_parity_lines[k]        = i_mem_rdata[k*LANE_W + LANE_D];
    end
  end

  // drive only during a read beat that does not follow a deselect; the
  // output drive pin acts without the clock, so there is no flop on it
  assign drive_ok      = (cur_op == OP_READ) && !first_desel && !asleep;
  assign o_dq_oe_n     = i_output_drive_l || !drive_ok;
  assign o_parity_oe_n = i_output_drive_l || !drive_ok;

  // ****************************************************************
  // checks
  // ****************************************************************
  property p_freeze;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      i_clock_gate_l |=> $stable(cur_op) && $stable(o_mem_raddr) && $stable(asleep);
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved while gated");

  property p_stretch;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      cur_op != OP_DESEL && i_clock_gate_l |=> cur_op != OP_DESEL;
  endproperty
  a_stretch: assert property (p_stretch) else $error("gate deselected the device");

  property p_deselect;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      en && !asleep && !i_advance_or_load && !selected |=> cur_op == OP_DESEL;
  endproperty
  a_deselect: assert property (p_deselect) else $error("bad select decode");

  property p_read_addr;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      en && !asleep && !i_advance_or_load && selected && i_write_req_l |=>
        cur_op == OP_READ &&
        o_mem_raddr == {$past(i_addr_hi), $past(i_burst_start_bit1), $past(i_burst_start_bit0)};
  endproperty
  a_read_addr: assert property (p_read_addr) else $error("read address not latched");

  property p_oe_high;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      i_output_drive_l |-> o_dq_oe_n && o_parity_oe_n;
  endproperty
  a_oe_high: assert property (p_oe_high) else $error("driving with drive pin high");

  property p_mask;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      cur_op != OP_READ || first_desel |-> o_dq_oe_n && o_parity_oe_n;
  endproperty
  a_mask: assert property (p_mask) else $error("outputs not masked");

  property p_first_after_desel;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      en && cur_op == OP_DESEL && !asleep && !i_advance_or_load && selected
        |=> o_dq_oe_n;
  endproperty
  a_first_after_desel: assert property (p_first_after_desel) else $error("drove after deselect");

  property p_write_capture;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      en && !asleep && cur_op == OP_WRITE |=>
        mem_we_q && o_mem_wdata == $past(pin_word) && o_mem_lane_we == ~$past(lanes_l);
  endproperty
  a_write_capture: assert property (p_write_capture) else $error("write data not captured");

  property p_sleep_hold;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      en && asleep |=> !mem_we_q && cur_op == OP_DESEL;
  endproperty
  a_sleep_hold: assert property (p_sleep_hold) else $error("access while asleep");

endmodule // fts_sram_ctl

// >>> design/fts_pkg.sv
/*
 * constants and types shared by the flow-through burst memory pin-control block.
 * assumes one rising-edge clock shared with the controller that drives the pins.
 */
package fts_pkg;

  // ****************************************************************
  // widths
  // ****************************************************************
  localparam int ADDR_W  = 18;
  localparam int HI_W    = 16;
  localparam int LANES   = 4;
  localparam int LANE_D  = 8;
  localparam int LANE_W  = 9;
  localparam int DATA_W  = 32;
  localparam int WORD_W  = 36;
  localparam int BURST_W = 2;

  // ****************************************************************
  // encodings and reset values
  // ****************************************************************
  localparam logic             STRAP_LINEAR   = 1'b0;
  localparam logic [BURST_W-1:0] BURST_RST    = 2'h0;
  localparam logic [BURST_W-1:0] BURST_ONE    = 2'h1;
  localparam logic             SLEEP_RST      = 1'b0;

  typedef enum logic [1:0] {
    OP_DESEL,
    OP_READ,
    OP_WRITE
  } fts_op_t;

endpackage

// >>> design/fts_burst_if.sv
/*
 * bundle between the pin-control block and its burst counter.
 * assumes both ends run on the same clock and clock gate.
 */
`timescale 1ns/1ps
interface fts_burst_if;
  logic                      load;     // take a new start value
  logic                      step;     // advance one beat
  logic                      linear;   // burst order from the strap
  logic [fts_pkg::BURST_W-1:0] seed;   // two low address bits
  logic [fts_pkg::BURST_W-1:0] addr_low;

  modport ctl (output load, output step, output linear, output seed, input addr_low);
  modport ctr (input load, input step, input linear, input seed, output addr_low);
endinterface

// >>> design/fts_burst_ctr.sv
/*
 * two-bit burst counter producing the low address bits of each beat.
 * assumes load and step are only raised on qualified edges.
 */
`timescale 1ns/1ps
module fts_burst_ctr (
  // clock and reset
  input  wire logic i_clk_sys,
  input  wire logic i_rst_n,
  input  wire logic i_en,
  // control bundle
  fts_burst_if.ctr  bus
);
  import fts_pkg::*;

  logic [BURST_W-1:0] start;
  logic [BURST_W-1:0] cnt;
  logic [BURST_W-1:0] next_start;
  logic [BURST_W-1:0] next_cnt;

  // ****************************************************************
  // counter
  // ****************************************************************
  // load reseeds and clears the beat count; step wraps modulo four
  always_comb begin
    next_start = start;
    next_cnt   = cnt;
    if (bus.load) begin
      next_start = bus.seed;
      next_cnt   = BURST_RST;
    end else if (bus.step) begin
      next_cnt = BURST_W'(cnt + BURST_ONE);
    end
  end

  // gate high holds the count, so a stretched beat repeats its address
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      start <= BURST_RST;
      cnt   <= BURST_RST;
    end else if (i_en) begin
      start <= next_start;
      cnt   <= next_cnt;
    end
  end

  // linear adds the count, interleaved xors it
  assign bus.addr_low = bus.linear ? BURST_W'(start + cnt) : (start ^ cnt);

  // ****************************************************************
  // checks
  // ****************************************************************
  property p_linear_step;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      i_en && bus.step && !bus.load && bus.linear |=>
        bus.addr_low == BURST_W'($past(bus.addr_low) + BURST_ONE);
  endproperty
  a_linear_step: assert property (p_linear_step) else $error("linear beat not incremented");

  property p_load_seed;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      i_en && bus.load |=> bus.addr_low == $past(bus.seed);
  endproperty
  a_load_seed: assert property (p_load_seed) else $error("first beat not the seed");

endmodule // fts_burst_ctr

// >>> dv/fts_array_model.sv
/*
 * storage array model standing behind the pin-control block's array port.
 * assumes one rising-edge clock; reads are combinational, writes land per lane.
 */
`timescale 1ns/1ps
module fts_array_model (
  // clock
  input  wire logic                       i_clk_sys,
  // array port
  input  wire logic [fts_pkg::ADDR_W-1:0] i_raddr,
  output logic      [fts_pkg::WORD_W-1:0] o_rdata,
  input  wire logic                       i_we,
  input  wire logic [fts_pkg::ADDR_W-1:0] i_waddr,
  input  wire logic [fts_pkg::WORD_W-1:0] i_wdata,
  input  wire logic [fts_pkg::LANES-1:0]  i_lane_we
);
  import fts_pkg::*;

  // ************
  // storage
  // ************
  // only 1024 words kept: the bench stays below that, higher bits alias
  logic [WORD_W-1:0] mem [0:1023];

  // seed pattern, mirrored by the bench's shadow copy
  initial begin
    for (int i = 0; i < 1024; i++) begin
      mem[i] = 36'hA5A5A5A5A ^ 36'(i);
    end
  end

  // flow-through read path
  assign o_rdata = mem[i_raddr[9:0]];

  // lane writes only on edges where the strobe is high
  always @(posedge i_clk_sys) begin
    if (i_we) begin
      for (int k = 0; k < LANES; k++) begin
        if (i_lane_we[k]) begin
          mem[i_waddr[9:0]][9*k +: 9] <= i_wdata[9*k +: 9];
        end
      end
    end
  end
endmodule // fts_array_model

// >>> dv/flow_through_sram_pin_control_tb.sv
/*
 * self-checking bench for the flow-through pin-control block: pins driven at
 * the falling edge, a shadow of the array, results checked in order.
 * assumes fts_pkg and the array model are compiled ahead of it.
 */
`timescale 1ns/1ps
module flow_through_sram_pin_control_tb;
  import fts_pkg::*;

  // ************
  // pins, shadow and notes
  // ************
  localparam logic [2:0] SEL = 3'h2;  // first low, second high, third low
  localparam logic [2:0] DES = 3'h6;  // first high: not selected
  logic              i_clk_sys, i_rst_n, gate_l, adv, wr_l, drive_l, drv, sleep, strap;
  logic              dq_oe_n, par_oe_n, mem_we, sleep_act;
  logic [2:0]        sel;
  logic [HI_W-1:0]   ahi;
  logic [1:0]        alo;
  logic [LANES-1:0]  lanes_l, par_in, par_out, lane_we;
  logic [DATA_W-1:0] dq_in, dq_out;
  logic [ADDR_W-1:0] raddr, waddr;
  logic [WORD_W-1:0] rdata, wdata;
  logic [WORD_W-1:0] shadow [0:1023];
  logic [WORD_W-1:0] rq [$];   // read words in order
  logic [57:0]       wq [$];   // {addr, word, lanes} in order
  int                n_fail, n_checks;

  fts_sram_ctl fts_sram_ctl_inst (
    .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_clock_gate_l(gate_l),
    .i_select_first_l(sel[2]), .i_select_second_h(sel[1]), .i_select_third_l(sel[0]),
    .i_advance_or_load(adv), .i_write_req_l(wr_l), .i_byte_lane_write_l(lanes_l),
    .i_addr_hi(ahi), .i_burst_start_bit0(alo[0]), .i_burst_start_bit1(alo[1]),
    .i_output_drive_l(drive_l), .i_sleep_request(sleep), .i_burst_order_strap(strap),
    .i_dq(dq_in), .o_dq(dq_out), .o_dq_oe_n(dq_oe_n), .i_parity_lines(par_in),
    .o_parity_lines(par_out), .o_parity_oe_n(par_oe_n), .o_mem_raddr(raddr),
    .i_mem_rdata(rdata), .o_mem_we(mem_we), .o_mem_waddr(waddr), .o_mem_wdata(wdata),
    .o_mem_lane_we(lane_we), .o_sleep_active(sleep_act)
  );

  fts_array_model fts_array_model_inst (
    .i_clk_sys(i_clk_sys), .i_raddr(raddr), .o_rdata(rdata), .i_we(mem_we),
    .i_waddr(waddr), .i_wdata(wdata), .i_lane_we(lane_we)
  );

  // free-running 125 MHz clock
  initial begin
    i_clk_sys = 1'h0;
    forever #4 i_clk_sys = ~i_clk_sys;
  end

  // ************
  // helpers
  // ************
  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    n_checks++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic conclude();
    if (n_fail == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  function automatic logic [WORD_W-1:0] pk(input logic [DATA_W-1:0] d, input logic [3:0] p);
    for (int k = 0; k < LANES; k++) pk[9*k +: 9] = {p[k], d[8*k +: 8]};
  endfunction

  function automatic logic [WORD_W-1:0] rnd();
    return WORD_W'({$urandom, $urandom});
  endfunction

  // beat k of a burst; order follows the strap held during reset
  function automatic logic [ADDR_W-1:0] ba(input logic [ADDR_W-1:0] a, input logic [1:0] k);
    return {a[ADDR_W-1:2], strap ? a[1:0] ^ k : a[1:0] + k};
  endfunction

  // one bus cycle: checks the cycle just ended, then drives the next one
  task automatic cmd(input int eoe, input logic [2:0] s, input logic a, input logic w,
                     input logic [ADDR_W-1:0] ad, input logic [3:0] bl,
                     input logic [WORD_W-1:0] d);
    @(negedge i_clk_sys);
    if (eoe >= 0) chk("oe_n", 64'(eoe), 64'(dq_oe_n));
    {gate_l, sel, adv, wr_l, lanes_l, drive_l} = {1'h0, s, a, w, bl, drv};
    {ahi, alo} = ad;
    for (int k = 0; k < LANES; k++) {par_in[k], dq_in[8*k +: 8]} = d[9*k +: 9];
  endtask

  // gate held high with junk on the select, advance, write and high address pins: nothing may move
  task automatic hold(input int n, input int eoe);
    repeat (n) begin
      @(negedge i_clk_sys);
      chk("oe_n", 64'(eoe), 64'(dq_oe_n));
      {gate_l, sel, adv, wr_l} = {1'h1, 5'($urandom)};
      ahi = 16'($urandom);
    end
  endtask

  // note a write and fold its lanes into the shadow
  task automatic wexp(input logic [ADDR_W-1:0] a, input logic [3:0] bl, input logic [35:0] d);
    wq.push_back({a, d, ~bl});
    for (int k = 0; k < LANES; k++) if (!bl[k]) shadow[a[9:0]][9*k +: 9] = d[9*k +: 9];
  endtask

  // burst write of n beats, lanes picked per beat, closed by a deselect
  task automatic wburst(input logic [ADDR_W-1:0] a, input int n);
    logic [3:0]        bl;
    logic [WORD_W-1:0] d;
    bl = 4'($urandom_range(14, 0));
    cmd(-1, SEL, 1'h0, 1'h0, a, bl, rnd());
    for (int k = 1; k <= n; k++) begin
      d = rnd();
      wexp(ba(a, 2'(k - 1)), bl, d);
      bl = 4'($urandom_range(14, 0));
      if (k < n) cmd(1, SEL, 1'h1, 1'h0, a, bl, d);
      else cmd(1, DES, 1'h0, 1'h1, a, 4'hF, d);
    end
  endtask

  // burst read of n beats; m marks a first beat masked after a deselect
  task automatic rburst(input logic [ADDR_W-1:0] a, input int n, input bit m);
    logic [ADDR_W-1:0] b;
    cmd(-1, SEL, 1'h0, 1'h1, a, 4'hF, rnd());
    if (!m) rq.push_back(shadow[a[9:0]]);
    for (int k = 1; k < n; k++) begin
      b = ba(a, 2'(k));
      rq.push_back(shadow[b[9:0]]);
      cmd((m && k == 1) ? 1 : 0, SEL, 1'h1, 1'h1, a, 4'hF, rnd());
    end
  endtask

  task automatic rst(input logic s);
    @(negedge i_clk_sys);
    {i_rst_n, gate_l, strap} = {1'h0, 1'h1, s};
    repeat (12) @(negedge i_clk_sys);
    i_rst_n = 1'h1;
  endtask

  // bounded wait on the synchronised sleep level, gate kept low
  task automatic wt(input logic e);
    for (int i = 0; i < 20 && sleep_act !== e; i++) cmd(-1, DES, 1'h0, 1'h1, '0, 4'hF, rnd());
    chk("sleep_active", 64'(e), 64'(sleep_act));
    if (sleep_act !== e) conclude();
  endtask

  // results as they appear, each matched with the oldest note
  always @(posedge i_clk_sys) begin
    // an unknown strobe or enable would silently skip the checks below
    if (i_rst_n && $isunknown({dq_oe_n, par_oe_n, mem_we})) chk("ctl_known", 64'(0), 64'(1));
    if (!gate_l && !dq_oe_n) begin
      chk("par_oe_n", 64'(0), 64'(par_oe_n));
      chk("rdata", 64'(rq.size() ? rq.pop_front() : 'x), 64'(pk(dq_out, par_out)));
    end
    if (mem_we) begin
      chk("write", 64'(wq.size() ? wq.pop_front() : 'x), 64'({waddr, wdata, lane_we}));
    end
  end

  // ************
  // main sequence
  // ************
  initial begin
    n_fail = 0;
    n_checks = 0;
    void'($urandom(32'hB535));
    for (int i = 0; i < 1024; i++) shadow[i] = 36'hA5A5A5A5A ^ 36'(i);
    {i_rst_n, gate_l, sel, adv, wr_l, ahi, alo} = {1'h0, 1'h1, DES, 1'h0, 1'h1, 18'h0};
    {lanes_l, dq_in, par_in, drive_l, drv} = {4'hF, 36'h0, 2'h0};
    sleep = 1'h0;
    strap = STRAP_LINEAR;
    rst(STRAP_LINEAR);
    wburst(18'h011, 4);
    rburst(18'h011, 4, 1'h1);
    rburst(18'h012, 2, 1'h0);
    // read stretched by the gate, then advanced
    cmd(0, SEL, 1'h0, 1'h1, 18'h012, 4'hF, rnd());
    rq.push_back(shadow[10'h012]);
    hold(3, 0);
    rq.push_back(shadow[10'h013]);
    cmd(0, SEL, 1'h1, 1'h1, 18'h0, 4'hF, rnd());
    cmd(0, DES, 1'h0, 1'h1, 18'h0, 4'hF, rnd());
    // write strobe frozen while the gate is high
    wburst(18'h050, 1);
    hold(2, 1);
    // every select combination; only one may write
    for (int s = 0; s < 8; s++) begin
      wdata_tmp_loop(s);
    end
    rburst(18'h020, 4, 1'h1);
    rburst(18'h024, 4, 1'h0);
    // output drive pin high during two read beats; the pin acts at once, so the
    // beats it covers are never seen by the watcher and get no note
    cmd(0, SEL, 1'h0, 1'h1, 18'h030, 4'hF, rnd());
    rq.push_back(shadow[10'h030]);
    cmd(0, SEL, 1'h1, 1'h1, 18'h0, 4'hF, rnd());
    drv = 1'h1;
    cmd(0, SEL, 1'h1, 1'h1, 18'h0, 4'hF, rnd());
    cmd(1, DES, 1'h0, 1'h1, 18'h0, 4'hF, rnd());
    drv = 1'h0;
    cmd(1, DES, 1'h0, 1'h1, 18'h0, 4'hF, rnd());
    cmd(1, DES, 1'h0, 1'h1, 18'h0, 4'hF, rnd());
    // sleep: a write is ignored and contents survive
    sleep = 1'h1;
    wt(1'h1);
    cmd(-1, SEL, 1'h0, 1'h0, 18'h011, 4'h0, rnd());
    cmd(1, DES, 1'h0, 1'h1, 18'h0, 4'hF, rnd());
    sleep = 1'h0;
    wt(1'h0);
    rburst(18'h010, 2, 1'h1);
    cmd(0, DES, 1'h0, 1'h1, 18'h0, 4'hF, rnd());
    // interleaved order after a second reset
    rst(1'h1);
    wburst(18'h041, 4);
    rburst(18'h041, 4, 1'h1);
    repeat (3) cmd(-1, DES, 1'h0, 1'h1, 18'h0, 4'hF, rnd());
    chk("pending", 64'(0), 64'(rq.size() + wq.size()));
    conclude();
  end

  // one select combination: a write load, then a deselect carrying data
  task automatic wdata_tmp_loop(input int s);
    logic [WORD_W-1:0] d;
    d = rnd();
    cmd(-1, 3'(s), 1'h0, 1'h0, 18'h020 + 18'(s), 4'h0, rnd());
    if (3'(s) == SEL) wexp(18'h020 + 18'(s), 4'h0, d);
    cmd(1, DES, 1'h0, 1'h1, 18'h0, 4'hF, d);
  endtask
endmodule // flow_through_sram_pin_control_tb
